//--- dmx_move_map.vh
// constants for the data-move instruction executor
`ifndef DMX_MOVE_MAP_VH
`define DMX_MOVE_MAP_VH

`define DMX_WORD_W       14
`define DMX_MEM_AW       8
`define DMX_MEM_DEPTH    256

`define DMX_OP_NOP       14'h0000
`define DMX_OP_RESET     14'h0001
`define DMX_OP_OPTION    14'h0002
`define DMX_MASK_BANK    14'h3FE0
`define DMX_PAT_BANK     14'h0020
`define DMX_MASK_STWF    14'h3F80
`define DMX_PAT_STWF     14'h0080
`define DMX_MASK_PCLAT   14'h3F80
`define DMX_PAT_PCLAT    14'h3180
`define DMX_MASK_LDWL    14'h3F00
`define DMX_PAT_LDWL     14'h3000
`define DMX_MASK_IMODE   14'h3FF8
`define DMX_PAT_ILDM     14'h0010
`define DMX_PAT_ISTM     14'h0018
`define DMX_MASK_IREL    14'h3F80
`define DMX_PAT_ILDK     14'h3F00
`define DMX_PAT_ISTK     14'h3F80

`define DMX_MODE_PREINC  2'h0
`define DMX_MODE_PREDEC  2'h1
`define DMX_MODE_POSTINC 2'h2
`define DMX_MODE_POSTDEC 2'h3

`define DMX_WIN0_ADDR    7'h00
`define DMX_WIN1_ADDR    7'h01

`define DMX_REG_WORK     4'h0
`define DMX_REG_BANK     4'h1
`define DMX_REG_PCLAT    4'h2
`define DMX_REG_OPTION   4'h3
`define DMX_REG_PTR0L    4'h4
`define DMX_REG_PTR0H    4'h5
`define DMX_REG_PTR1L    4'h6
`define DMX_REG_PTR1H    4'h7
`define DMX_REG_STATUS   4'h8
`define DMX_REG_PWRCTL   4'h9

`define DMX_STATUS_ZERO  0
`define DMX_PWRCTL_NRI   0

`define DMX_RST_WORK     8'h00
`define DMX_RST_BANK     5'h00
`define DMX_RST_PCLAT    7'h00
`define DMX_RST_OPTION   8'hFF
`define DMX_RST_PTR      16'h0000

`endif

//--- dmx_ptr_unit.v
// effective address and pointer update for indirect moves
`timescale 1ns/10ps
`default_nettype none
`include "dmx_move_map.vh"

module dmx_ptr_unit (
  input  wire [15:0] ptrIn,
  input  wire        relMode,
  input  wire [1:0]  ptrMode,
  input  wire [5:0]  relOffset,
  output reg  [15:0] effAddr,
  output reg  [15:0] ptrNext
);

  wire [15:0] offExt;
  wire [15:0] ptrInc;
  wire [15:0] ptrDec;

  assign offExt = {{10{relOffset[5]}}, relOffset};
  assign ptrInc = ptrIn + 16'h0001;
  assign ptrDec = ptrIn - 16'h0001;

  always @* begin
    effAddr = ptrIn;
    ptrNext = ptrIn;
    if (relMode) begin
      effAddr = ptrIn + offExt;
      ptrNext = ptrIn;
    end else begin
      case (ptrMode)
        `DMX_MODE_PREINC: begin
          effAddr = ptrInc;
          ptrNext = ptrInc;
        end
        `DMX_MODE_PREDEC: begin
          effAddr = ptrDec;
          ptrNext = ptrDec;
        end
        `DMX_MODE_POSTINC: begin
          effAddr = ptrIn;
          ptrNext = ptrInc;
        end
        `DMX_MODE_POSTDEC: begin
          effAddr = ptrIn;
          ptrNext = ptrDec;
        end
        default: begin
          effAddr = ptrIn;
          ptrNext = ptrIn;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- dmx_move_exec.v
// data-move and control instruction executor
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dmx_move_map.vh"

module dmx_move_exec (
  input  wire                   clk,
  input  wire                   nrst,
  input  wire                   instrValid,
  input  wire [`DMX_WORD_W-1:0] instrWord,
  output wire                   instrReady,
  input  wire [3:0]             regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWr,
  input  wire                   regRd,
  output reg  [7:0]             regRdData,
  output reg  [7:0]             workingReg,
  output reg  [4:0]             bankSelReg,
  output reg  [6:0]             pcHighLatch,
  output reg  [7:0]             optionReg,
  output wire [15:0]            indirectPtr0,
  output wire [15:0]            indirectPtr1,
  output reg                    zeroFlag,
  output reg                    resetInstrFlagN,
  output reg                    deviceResetReq
);

  reg  [7:0]              dataMem [0:`DMX_MEM_DEPTH-1];
  wire [31:0]             ptrFlat;
  wire                    fire;
  wire                    isReset;
  wire                    isOption;
  wire                    isBank;
  wire                    isStoreFile;
  wire                    isPcLatch;
  wire                    isLoadWork;
  wire                    isIstMode;
  wire                    isIldMode;
  wire                    isIstRel;
  wire                    isIldRel;
  wire                    isIndStore;
  wire                    isIndLoad;
  wire                    isIndirect;
  wire                    relForm;
  wire                    ptrSel;
  wire [15:0]             ptrCur;
  wire [15:0]             effAddr;
  wire [15:0]             ptrNext;
  wire [6:0]              fileAddr;
  wire [11:0]             directFull;
  wire                    toWin0;
  wire                    toWin1;
  reg  [15:0]             storeAddrFull;
  wire [`DMX_MEM_AW-1:0]  memWrAddr;
  wire [`DMX_MEM_AW-1:0]  memRdAddr;
  wire [7:0]              memRdData;
  wire                    memWe;
  reg  [7:0]              rdMux;

  assign fire        = instrValid & ~deviceResetReq;
  assign instrReady  = ~deviceResetReq;

  // decode
  assign isReset     = (instrWord == `DMX_OP_RESET);
  assign isOption    = (instrWord == `DMX_OP_OPTION);
  assign isBank      = ((instrWord & `DMX_MASK_BANK) == `DMX_PAT_BANK);
  assign isStoreFile = ((instrWord & `DMX_MASK_STWF) == `DMX_PAT_STWF);
  assign isPcLatch   = ((instrWord & `DMX_MASK_PCLAT) == `DMX_PAT_PCLAT);
  assign isLoadWork  = ((instrWord & `DMX_MASK_LDWL) == `DMX_PAT_LDWL);
  assign isIstMode   = ((instrWord & `DMX_MASK_IMODE) == `DMX_PAT_ISTM);
  assign isIldMode   = ((instrWord & `DMX_MASK_IMODE) == `DMX_PAT_ILDM);
  assign isIstRel    = ((instrWord & `DMX_MASK_IREL) == `DMX_PAT_ISTK);
  assign isIldRel    = ((instrWord & `DMX_MASK_IREL) == `DMX_PAT_ILDK);
  assign isIndStore  = isIstMode | isIstRel;
  assign isIndLoad   = isIldMode | isIldRel;
  assign isIndirect  = isIndStore | isIndLoad;
  assign relForm     = isIstRel | isIldRel;
  assign ptrSel      = relForm ? instrWord[6] : instrWord[2];

  assign indirectPtr0 = ptrFlat[15:0];
  assign indirectPtr1 = ptrFlat[31:16];
  assign ptrCur       = ptrSel ? indirectPtr1 : indirectPtr0;

  dmx_ptr_unit i_dmx_ptr_unit (
    .ptrIn     (ptrCur),
    .relMode   (relForm),
    .ptrMode   (instrWord[1:0]),
    .relOffset (instrWord[5:0]),
    .effAddr   (effAddr),
    .ptrNext   (ptrNext)
  );

  // addressing
  assign fileAddr   = instrWord[6:0];
  assign directFull = {bankSelReg, fileAddr};
  assign toWin0     = (fileAddr == `DMX_WIN0_ADDR);
  assign toWin1     = (fileAddr == `DMX_WIN1_ADDR);

  always @* begin
    storeAddrFull = {4'h0, directFull};
    if (isIndStore) begin
      storeAddrFull = effAddr;
    end else if (toWin0) begin
      storeAddrFull = indirectPtr0;
    end else if (toWin1) begin
      storeAddrFull = indirectPtr1;
    end
  end

  assign memWrAddr = storeAddrFull[`DMX_MEM_AW-1:0];
  assign memRdAddr = effAddr[`DMX_MEM_AW-1:0];
  assign memRdData = dataMem[memRdAddr];
  assign memWe     = fire & (isIndStore | isStoreFile);

  // file memory, no reset
  always @(posedge clk) begin
    if (memWe) begin
      dataMem[memWrAddr] <= workingReg;
    end
  end

  // pointers, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gPtr
      reg  [15:0] ptr_r;
      wire        hit;
      wire [3:0]  loOff;
      wire [3:0]  hiOff;
      assign hit   = fire & isIndirect & ((gi == 1) ? ptrSel : ~ptrSel);
      assign loOff = (gi == 1) ? `DMX_REG_PTR1L : `DMX_REG_PTR0L;
      assign hiOff = (gi == 1) ? `DMX_REG_PTR1H : `DMX_REG_PTR0H;
      assign ptrFlat[16*gi +: 16] = ptr_r;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ptr_r <= `DMX_RST_PTR;
        end else if (deviceResetReq) begin
          ptr_r <= `DMX_RST_PTR;
        end else if (hit) begin
          ptr_r <= ptrNext;
        end else if (regWr && regAddr == loOff) begin
          ptr_r <= {ptr_r[15:8], regWrData};
        end else if (regWr && regAddr == hiOff) begin
          ptr_r <= {regWrData, ptr_r[7:0]};
        end
      end
    end
  endgenerate

  // core state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      workingReg  <= `DMX_RST_WORK;
      bankSelReg  <= `DMX_RST_BANK;
      pcHighLatch <= `DMX_RST_PCLAT;
      optionReg   <= `DMX_RST_OPTION;
      zeroFlag    <= 1'h0;
    end else if (deviceResetReq) begin
      workingReg  <= `DMX_RST_WORK;
      bankSelReg  <= `DMX_RST_BANK;
      pcHighLatch <= `DMX_RST_PCLAT;
      optionReg   <= `DMX_RST_OPTION;
      zeroFlag    <= 1'h0;
    end else if (fire) begin
      if (isBank) begin
        bankSelReg <= instrWord[4:0];
      end
      if (isPcLatch) begin
        pcHighLatch <= instrWord[6:0];
      end
      if (isLoadWork) begin
        workingReg <= instrWord[7:0];
      end
      if (isOption) begin
        optionReg <= workingReg;
      end
      if (isIndLoad) begin
        workingReg <= memRdData;
        zeroFlag   <= (memRdData == 8'h00);
      end
    end
  end

  // software reset pulse and indicator
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deviceResetReq  <= 1'h0;
      resetInstrFlagN <= 1'h1;
    end else begin
      deviceResetReq <= fire & isReset;
      if (fire && isReset) begin
        resetInstrFlagN <= 1'b0;
      end else if (regWr && regAddr == `DMX_REG_PWRCTL) begin
        resetInstrFlagN <= regWrData[`DMX_PWRCTL_NRI];
      end
    end
  end

  // register read port
  always @* begin
    rdMux = 8'h00;
    case (regAddr)
      `DMX_REG_WORK:   rdMux = workingReg;
      `DMX_REG_BANK:   rdMux = {3'h0, bankSelReg};
      `DMX_REG_PCLAT:  rdMux = {1'h0, pcHighLatch};
      `DMX_REG_OPTION: rdMux = optionReg;
      `DMX_REG_PTR0L:  rdMux = indirectPtr0[7:0];
      `DMX_REG_PTR0H:  rdMux = indirectPtr0[15:8];
      `DMX_REG_PTR1L:  rdMux = indirectPtr1[7:0];
      `DMX_REG_PTR1H:  rdMux = indirectPtr1[15:8];
      `DMX_REG_STATUS: rdMux = {7'h00, zeroFlag};
      `DMX_REG_PWRCTL: rdMux = {7'h00, resetInstrFlagN};
      default:         rdMux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- dmx_move_exec_props.sv
// assertion checker for the data-move executor
`timescale 1ns/10ps
`default_nettype none
`include "dmx_move_map.vh"
module dmx_move_exec_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        instrValid,
  input wire logic [13:0] instrWord,
  input wire logic        instrReady,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  input wire logic [7:0]  workingReg,
  input wire logic [4:0]  bankSelReg,
  input wire logic [6:0]  pcHighLatch,
  input wire logic [7:0]  optionReg,
  input wire logic [15:0] indirectPtr0,
  input wire logic [15:0] indirectPtr1,
  input wire logic        zeroFlag,
  input wire logic        resetInstrFlagN,
  input wire logic        deviceResetReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire        tk = instrValid && instrReady;
  wire [13:0] iw = instrWord;
  sequence s_rstHigh;
    deviceResetReq && !resetInstrFlagN && !instrReady;
  endsequence
  sequence s_rstDone;
    !deviceResetReq && workingReg == 8'h00 && optionReg == 8'hFF;
  endsequence
  a_bank_load: assert property (tk && (iw & `DMX_MASK_BANK) == `DMX_PAT_BANK |=> bankSelReg == $past(iw[4:0]))
    else $error("bank select not loaded");
  a_latch_load: assert property (tk && (iw & `DMX_MASK_PCLAT) == `DMX_PAT_PCLAT |=> pcHighLatch == $past(iw[6:0]))
    else $error("pc latch not loaded");
  a_work_load: assert property (tk && (iw & `DMX_MASK_LDWL) == `DMX_PAT_LDWL |=> workingReg == $past(iw[7:0]))
    else $error("working literal not loaded");
  a_option_copy: assert property (tk && iw == `DMX_OP_OPTION |=> optionReg == $past(workingReg))
    else $error("option not copied");
  a_zero_kept: assert property (tk && ((iw & `DMX_MASK_IMODE) == `DMX_PAT_ISTM || (iw & `DMX_MASK_LDWL) == `DMX_PAT_LDWL) |=> $stable(zeroFlag))
    else $error("zero flag disturbed");
  a_ptr_step: assert property (tk && (iw & `DMX_MASK_IMODE) == `DMX_PAT_ISTM && !iw[2] |=> indirectPtr0 == $past(indirectPtr0) + ($past(iw[0]) ? 16'hFFFF : 16'h0001))
    else $error("pointer step wrong");
  a_rel_keep: assert property (tk && (iw & `DMX_MASK_IREL) == `DMX_PAT_ISTK && iw[6] |=> $stable(indirectPtr1))
    else $error("relative form moved pointer");
  a_soft_reset: assert property (tk && iw == `DMX_OP_RESET |=> s_rstHigh ##1 s_rstDone)
    else $error("soft reset sequence wrong");
  a_rd_idle: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data outside read slot");
endmodule
bind dmx_move_exec dmx_move_exec_props i_props (.clk, .nrst, .instrValid, .instrWord, .instrReady, .regRd,
  .regRdData, .workingReg, .bankSelReg, .pcHighLatch, .optionReg, .indirectPtr0, .indirectPtr1, .zeroFlag,
  .resetInstrFlagN, .deviceResetReq);
`default_nettype wire

//--- dmx_move_exec_bench.sv
// self-checking bench for the data-move executor
`timescale 1ns/10ps
`default_nettype none
`include "dmx_move_map.vh"
module dmx_move_exec_bench;
  logic        clk = 0;
  logic        nrst = 0;
  logic        instrValid = 0;
  logic [13:0] instrWord = 0;
  logic [3:0]  regAddr = 0;
  logic [7:0]  regWrData = 0;
  logic        regWr = 0;
  logic        regRd = 0;
  wire         instrReady, zeroFlag, resetInstrFlagN, deviceResetReq;
  wire  [7:0]  regRdData, workingReg, optionReg;
  wire  [4:0]  bankSelReg;
  wire  [6:0]  pcHighLatch;
  wire  [15:0] indirectPtr0, indirectPtr1;
  int          fails = 0;
  int          testsRun = 0;
  dmx_move_exec i_dmx_move_exec (.clk, .nrst, .instrValid, .instrWord, .instrReady, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .workingReg, .bankSelReg, .pcHighLatch, .optionReg, .indirectPtr0,
    .indirectPtr1, .zeroFlag, .resetInstrFlagN, .deviceResetReq);
  always #25 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input logic v, input logic [13:0] w, input logic we, input logic re,
                     input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    instrValid <= v;
    instrWord <= w;
    regWr <= we;
    regRd <= re;
    regAddr <= a;
    regWrData <= d;
    @(negedge clk);
  endtask
  task automatic idle;
    cyc(0, 0, 0, 0, 0, 0);
  endtask
  task automatic ex(input logic [13:0] w);
    cyc(1, w, 0, 0, 0, 0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cyc(0, 0, 1, 0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    cyc(0, 0, 0, 1, a, 0);
    idle;
    chk(regRdData, e);
  endtask
  task automatic setp(input logic n, input logic [15:0] v);
    wr({2'h1, n, 1'h0}, v[7:0]);
    wr({2'h1, n, 1'h1}, v[15:8]);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    rd(4'h3, 8'hFF);
    rd(4'hF, 8'h00);
    ex(14'h30A5);
    idle;
    chk(workingReg, 8'hA5);
    rd(4'h0, 8'hA5);
    ex(14'h002F);
    idle;
    chk(bankSelReg, 5'h0F);
    ex(14'h31FF);
    idle;
    chk(pcHighLatch, 7'h7F);
    ex(`DMX_OP_OPTION);
    idle;
    chk(optionReg, 8'hA5);
    $display("literal test done");
    for (int m = 0; m < 4; m++) begin
      setp(0, 16'h0040);
      ex(14'h3011 + 14'(m));
      ex(`DMX_PAT_ISTM | 14'(m));
      idle;
      chk(indirectPtr0, m[0] ? 16'h003F : 16'h0041);
      ex(14'h3000);
      ex(`DMX_PAT_ILDK | (m == 2 ? 14'h3F : m == 3 ? 14'h01 : 14'h00));
      idle;
      chk(workingReg, 8'h11 + 8'(m));
    end
    $display("mode test done");
    setp(1, 16'hFFFF);
    ex(14'h3000);
    ex(`DMX_PAT_ISTM | 14'h4);
    idle;
    chk(indirectPtr1, 16'h0000);
    ex(`DMX_PAT_ISTM | 14'h5);
    idle;
    chk(indirectPtr1, 16'hFFFF);
    ex(14'h30FF);
    ex(`DMX_PAT_ILDK | 14'h41);
    idle;
    chk(zeroFlag, 1'h1);
    ex(14'h3055);
    idle;
    chk(zeroFlag, 1'h1);
    ex(`DMX_OP_NOP);
    idle;
    chk({zeroFlag, workingReg}, 9'h155);
    setp(1, 16'h0050);
    ex(14'h30C3);
    ex(`DMX_PAT_ISTK | 14'h60);
    idle;
    chk(indirectPtr1, 16'h0050);
    ex(14'h3000);
    ex(`DMX_PAT_ILDK | 14'h60);
    idle;
    chk(workingReg, 8'hC3);
    setp(0, 16'h0030);
    ex(14'h3077);
    ex(`DMX_PAT_STWF | `DMX_WIN0_ADDR);
    ex(14'h3000);
    ex(`DMX_PAT_ILDK | 14'h60);
    idle;
    chk(workingReg, 8'h77);
    ex(14'h0021);
    ex(14'h30E1);
    ex(`DMX_PAT_STWF | 14'h05);
    setp(0, 16'h0085);
    ex(14'h3000);
    ex(`DMX_PAT_ILDK);
    idle;
    chk(workingReg, 8'hE1);
    $display("indirect test done");
    ex(`DMX_OP_RESET);
    ex(14'h3099);
    chk({deviceResetReq, resetInstrFlagN, instrReady}, 3'h4);
    idle;
    chk(workingReg, 8'h00);
    chk(indirectPtr0, 16'h0000);
    chk(bankSelReg, 5'h00);
    chk(optionReg, 8'hFF);
    rd(4'h9, 8'h00);
    wr(4'h9, 8'h01);
    idle;
    chk(resetInstrFlagN, 1'h1);
    $display("soft reset test done");
    print_verdict;
  end
endmodule
`default_nettype wire
